// ### hdl/ars_adc_seq.v
// adc request sequencer: arbitration, timing, result storage and apb registers
`timescale 1ns/10ps
`default_nettype none
`include "ars_consts.vh"

module ars_adc_seq (
    // clock, reset, enable
    input wire clk_i,
    input wire srst_i,
    input wire ce_i,
    // apb slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [7:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output wire pready_o,
    output wire pslverr_o,
    // trigger and pin inputs
    input wire [3:0] ext_trig_i,
    input wire [15:0] ain_dig_i,
    // converter cores
    input wire [9:0] cv0_res_i,
    input wire [9:0] cv1_res_i,
    output wire cv_sample_o,
    output wire cv_convert_o,
    output reg [3:0] cv0_ch_o,
    output wire [3:0] cv1_ch_o,
    output wire cv1_en_o,
    output wire cv_res8_o,
    output wire cv_pd_o,
    output wire bw_pre_o,
    output wire mux_test_o,
    output reg [2:0] emux_sel_o,
    output wire [15:0] dig_dis_o,
    // transfer unit and interrupt
    output reg xfer_req_o,
    output wire irq_o
);
    localparam ST_IDLE = 3'd0;
    localparam ST_PRE = 3'd1;
    localparam ST_SAMP = 3'd2;
    localparam ST_CONV = 3'd3;
    localparam ST_STORE = 3'd4;
    localparam SRC_INJ = 2'd0;
    localparam SRC_PAR = 2'd1;
    localparam SRC_Q = 2'd2;
    // index of lowest set bit; bit 4 flags that one was found
    function [4:0] ars_first;
        input [15:0] v;
        integer k;
        begin
            ars_first = 5'h00;
            for (k = 15; k >= 0; k = k - 1) begin
                if (v[k]) begin
                    ars_first = {1'b1, k[3:0]};
                end
            end
        end
    endfunction
    // true for every offset the slave answers without an error response
    function ars_mapped;
        input [7:0] a;
        begin
            ars_mapped = (a[1:0] == 2'h0) && ((a <= `ARS_OFF_DIS) || (a[7:6] == `ARS_RES_BASE));
        end
    endfunction
    // control and configuration registers
    reg [31:0] ctrl_reg, tim_reg, lim_reg;
    reg [9:0] emux_reg;
    reg [7:0] wfr_reg;
    reg [15:0] dis_reg, par_sel_reg, par_pend_reg;
    reg [3:0] irq_stat_reg, irq_mask_reg;
    reg err_reg;
    // queue, injection, results
    reg [3:0] q_mem [0:3];
    reg [2:0] q_wp_reg, q_rp_reg;
    reg q_arm_reg;
    reg inj_pend_reg;
    reg [3:0] inj_ch_reg;
    reg [20:0] res0_mem [0:7];
    reg [9:0] res1_mem [0:7];
    reg [15:0] valid_reg;
    reg [2:0] wptr_reg, rptr_reg;
    // sequencer
    reg [2:0] state_reg;
    reg [11:0] cnt_reg;
    reg [1:0] src_reg;
    reg [2:0] idx_reg;
    reg [13:0] acc_reg;
    reg [1:0] acc_cnt_reg;
    // synchronisers
    reg [15:0] ain_s1, ain_s2;
    reg [3:0] trg_s1, trg_s2, trg_s3;
    // apb decode
    wire apb_setup = psel_i & ~penable_i;
    wire apb_acc = psel_i & penable_i;
    wire apb_wr = apb_acc & pwrite_i;
    wire apb_rd = apb_acc & ~pwrite_i;
    assign pready_o = apb_acc;
    assign pslverr_o = apb_acc & err_reg;
    wire wr_cmd = apb_wr && (paddr_i == `ARS_OFF_CMD);
    wire is_res = (paddr_i[7:6] == `ARS_RES_BASE);
    wire [3:0] res_ai = paddr_i[5:2];
    // converter configuration
    wire en = ctrl_reg[`ARS_CTRL_EN];
    wire res8 = ctrl_reg[`ARS_CTRL_RES8];
    wire sync = ctrl_reg[`ARS_CTRL_SYNC];
    wire chain = ctrl_reg[`ARS_CTRL_CHAIN];
    wire bwd = ctrl_reg[`ARS_CTRL_BWD];
    wire [1:0] red = ctrl_reg[`ARS_CTRL_RED];
    // triggers: only the settled stage feeds the edge detector
    wire [3:0] trg_rise = trg_s2 & ~trg_s3;
    wire par_go = (ctrl_reg[`ARS_CTRL_PTEN] & trg_rise[ctrl_reg[`ARS_CTRL_PTSEL]])
                | (wr_cmd & pwdata_i[`ARS_CMD_PSTART]);
    wire q_go = (ctrl_reg[`ARS_CTRL_QTEN] & trg_rise[ctrl_reg[`ARS_CTRL_QTSEL]])
              | (wr_cmd & pwdata_i[`ARS_CMD_QSTART]);
    wire q_flush = wr_cmd & pwdata_i[`ARS_CMD_QFLUSH];
    // queue status
    wire q_empty = (q_wp_reg == q_rp_reg);
    wire q_full = (q_wp_reg[1:0] == q_rp_reg[1:0]) && (q_wp_reg[2] != q_rp_reg[2]);
    wire [2:0] q_cnt = q_wp_reg - q_rp_reg;
    // arbitration: inserted channel always highest, then programmed levels
    wire [4:0] par_first = ars_first(par_pend_reg);
    wire par_req = par_first[4];
    wire q_req = q_arm_reg & ~q_empty;
    wire par_wins = par_req & (~q_req | (ctrl_reg[`ARS_CTRL_PPRIO] >= ctrl_reg[`ARS_CTRL_QPRIO]));
    reg [1:0] g_src;
    reg [3:0] g_ch;
    reg g_req;
    always @* begin
        g_req = 1'b1;
        g_src = SRC_INJ;
        g_ch = inj_ch_reg;
        if (inj_pend_reg) begin
            g_src = SRC_INJ;
        end else if (par_wins) begin
            g_src = SRC_PAR;
            g_ch = par_first[3:0];
        end else if (q_req) begin
            g_src = SRC_Q;
            g_ch = q_mem[q_rp_reg[1:0]];
        end else begin
            g_req = 1'b0;
        end
    end
    // target register and wait-for-read hold-off
    wire [2:0] g_idx = chain ? wptr_reg : g_ch[2:0];
    wire g_busy = valid_reg[g_idx] | (sync & valid_reg[{1'b1, g_idx}]);
    wire g_block = wfr_reg[g_idx] & g_busy;
    wire grant = ce_i & en & g_req & ~g_block & (state_reg == ST_IDLE);
    // conversion length: bits times per-bit period
    wire [8:0] cvp1 = {1'b0, tim_reg[`ARS_TIM_CONV]} + 9'h001;
    wire [11:0] conv_len = res8 ? {cvp1, 3'h0} : ({cvp1, 3'h0} + {2'h0, cvp1, 1'h0});
    wire [11:0] samp_len = {4'h0, tim_reg[`ARS_TIM_SAMP]};
    // result shaping and reduction
    wire [13:0] raw = res8 ? {6'h00, cv0_res_i[9:2]} : {4'h0, cv0_res_i};
    wire [13:0] acc_sum = acc_reg + raw;
    wire out_band = (raw[9:0] < lim_reg[`ARS_LIM_LO]) || (raw[9:0] > lim_reg[`ARS_LIM_HI]);
    wire acc_last = (acc_cnt_reg == ctrl_reg[`ARS_CTRL_ACCN]);
    wire in_store = (state_reg == ST_STORE);
    wire keep = (red == `ARS_RED_LIMIT) ? out_band :
                (red == `ARS_RED_ACC) ? acc_last : 1'b1;
    wire store = ce_i & in_store & keep;
    wire [13:0] st_val = (red == `ARS_RED_ACC) ? acc_sum : raw;
    // read side effects on result registers
    wire rd_res = ce_i & apb_rd & is_res & (paddr_i[1:0] == 2'h0);
    wire rd_fifo = ce_i & apb_rd & (paddr_i == `ARS_OFF_FIFO);
    wire [15:0] vclr = (rd_res ? (16'h0001 << res_ai) : 16'h0000)
                     | (rd_fifo ? (16'h0001 << rptr_reg) : 16'h0000);
    wire [15:0] vset = store ? ((16'h0001 << idx_reg) | ({15'h0000, sync} << {1'b1, idx_reg}))
                     : 16'h0000;
    // input synchronisers
    always @(posedge clk_i) begin
        if (srst_i) begin
            ain_s1 <= 16'h0000;
            ain_s2 <= 16'h0000;
            trg_s1 <= 4'h0;
            trg_s2 <= 4'h0;
            trg_s3 <= 4'h0;
        end else if (ce_i) begin
            ain_s1 <= ain_dig_i;
            ain_s2 <= ain_s1;
            trg_s1 <= ext_trig_i;
            trg_s2 <= trg_s1;
            trg_s3 <= trg_s2;
        end
    end
    // software-written configuration
    always @(posedge clk_i) begin
        if (srst_i) begin
            ctrl_reg <= `ARS_CTRL_RST;
            tim_reg <= `ARS_TIM_RST;
            lim_reg <= `ARS_LIM_RST;
            emux_reg <= 10'h000;
            wfr_reg <= 8'h00;
            dis_reg <= 16'h0000;
            par_sel_reg <= 16'h0000;
            irq_mask_reg <= 4'h0;
        end else if (ce_i && apb_wr) begin
            case (paddr_i)
                `ARS_OFF_CTRL: ctrl_reg <= pwdata_i;
                `ARS_OFF_TIM: tim_reg <= {16'h0000, pwdata_i[15:0]};
                `ARS_OFF_PSEL: par_sel_reg <= pwdata_i[15:0];
                `ARS_OFF_LIM: lim_reg <= {6'h00, pwdata_i[25:16], 6'h00, pwdata_i[9:0]};
                `ARS_OFF_WFR: wfr_reg <= pwdata_i[7:0];
                `ARS_OFF_EMUX: emux_reg <= pwdata_i[9:0];
                `ARS_OFF_IRQM: irq_mask_reg <= pwdata_i[3:0];
                `ARS_OFF_DIS: dis_reg <= pwdata_i[15:0];
                default: ctrl_reg <= ctrl_reg;
            endcase
        end
    end
    // request sources: activation wins over the grant that clears
    always @(posedge clk_i) begin
        if (srst_i) begin
            par_pend_reg <= 16'h0000;
            q_wp_reg <= 3'h0;
            q_rp_reg <= 3'h0;
            q_arm_reg <= 1'b0;
            inj_pend_reg <= 1'b0;
            inj_ch_reg <= 4'h0;
        end else if (ce_i) begin
            par_pend_reg <= (par_pend_reg & ~((grant && g_src == SRC_PAR) ?
                            (16'h0001 << g_ch) : 16'h0000)) | (par_go ? par_sel_reg : 16'h0000);
            if (q_flush) begin
                q_wp_reg <= 3'h0;
                q_rp_reg <= 3'h0;
                q_arm_reg <= 1'b0;
            end else begin
                if (apb_wr && paddr_i == `ARS_OFF_QUEUE && !q_full) begin
                    q_wp_reg <= q_wp_reg + 3'h1;
                end
                if (grant && g_src == SRC_Q) begin
                    q_rp_reg <= q_rp_reg + 3'h1;
                end
                if (q_go) begin
                    q_arm_reg <= 1'b1;
                end
            end
            if (apb_wr && paddr_i == `ARS_OFF_INJ) begin
                inj_pend_reg <= 1'b1;
                inj_ch_reg <= pwdata_i[3:0];
            end else if (grant && g_src == SRC_INJ) begin
                inj_pend_reg <= 1'b0;
            end
        end
    end
    // queue storage needs no reset; the pointers guard it
    always @(posedge clk_i) begin
        if (ce_i && apb_wr && paddr_i == `ARS_OFF_QUEUE && !q_full && !q_flush) begin
            q_mem[q_wp_reg[1:0]] <= pwdata_i[3:0];
        end
    end
    // conversion sequencer
    always @(posedge clk_i) begin
        if (srst_i) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 12'h000;
            src_reg <= SRC_INJ;
            idx_reg <= 3'h0;
            cv0_ch_o <= 4'h0;
        end else if (ce_i) begin
            case (state_reg)
                ST_IDLE: begin
                    if (grant) begin
                        src_reg <= g_src;
                        idx_reg <= g_idx;
                        cv0_ch_o <= g_ch;
                        cnt_reg <= samp_len;
                        state_reg <= bwd ? ST_PRE : ST_SAMP;
                    end
                end
                ST_PRE: begin
                    // precharge lasts one sample time so an open input drifts visibly
                    if (cnt_reg == 12'h000) begin
                        cnt_reg <= samp_len;
                        state_reg <= ST_SAMP;
                    end else begin
                        cnt_reg <= cnt_reg - 12'h001;
                    end
                end
                ST_SAMP: begin
                    if (cnt_reg == 12'h000) begin
                        cnt_reg <= conv_len - 12'h001;
                        state_reg <= ST_CONV;
                    end else begin
                        cnt_reg <= cnt_reg - 12'h001;
                    end
                end
                ST_CONV: begin
                    if (cnt_reg == 12'h000) begin
                        state_reg <= ST_STORE;
                    end else begin
                        cnt_reg <= cnt_reg - 12'h001;
                    end
                end
                ST_STORE: state_reg <= ST_IDLE;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end
    // reduction, result pointers, external mux stepping, transfer request
    always @(posedge clk_i) begin
        if (srst_i) begin
            acc_reg <= 14'h0000;
            acc_cnt_reg <= 2'h0;
            wptr_reg <= 3'h0;
            rptr_reg <= 3'h0;
            valid_reg <= 16'h0000;
            emux_sel_o <= 3'h0;
            xfer_req_o <= 1'b0;
        end else if (ce_i) begin
            valid_reg <= (valid_reg & ~vclr) | vset;
            xfer_req_o <= store;
            if (store && chain) begin
                wptr_reg <= wptr_reg + 3'h1;
            end
            if (rd_fifo) begin
                rptr_reg <= rptr_reg + 3'h1;
            end
            if (in_store && red == `ARS_RED_ACC) begin
                acc_reg <= acc_last ? 14'h0000 : acc_sum;
                acc_cnt_reg <= acc_last ? 2'h0 : acc_cnt_reg + 2'h1;
            end
            if (in_store && cv0_ch_o == emux_reg[`ARS_EMUX_CH]) begin
                // step after the conversion so the next sample sees a settled mux
                emux_sel_o <= (emux_sel_o == emux_reg[`ARS_EMUX_LAST]) ? 3'h0
                            : emux_sel_o + 3'h1;
            end
        end
    end
    // result storage for both converters, laid out as the read word
    always @(posedge clk_i) begin
        if (store) begin
            res0_mem[idx_reg] <= {bwd, cv0_ch_o, 2'h0, st_val};
            res1_mem[idx_reg] <= cv1_res_i;
        end
    end
    // sticky interrupt flags: a new event beats a same-cycle clear
    wire [3:0] irq_ev;
    assign irq_ev[`ARS_IRQ_DONE] = store;
    assign irq_ev[`ARS_IRQ_LIMIT] = store & (red == `ARS_RED_LIMIT);
    assign irq_ev[`ARS_IRQ_SEQEND] = grant & (g_src == SRC_PAR) & ~|(par_pend_reg & ~(16'h0001 << g_ch));
    assign irq_ev[`ARS_IRQ_BLOCK] = en & g_req & g_block & (state_reg == ST_IDLE);
    always @(posedge clk_i) begin
        if (srst_i) begin
            irq_stat_reg <= 4'h0;
        end else if (ce_i) begin
            irq_stat_reg <= (irq_stat_reg & ~((apb_wr && paddr_i == `ARS_OFF_IRQS) ?
                            pwdata_i[3:0] : 4'h0)) | irq_ev;
        end
    end
    assign irq_o = |(irq_stat_reg & irq_mask_reg);
    // read data is captured in the setup cycle, answered with zero wait
    reg [31:0] rd_next;
    always @* begin
        rd_next = 32'h0000_0000;
        case (paddr_i)
            `ARS_OFF_CTRL: rd_next = ctrl_reg;
            `ARS_OFF_TIM: rd_next = tim_reg;
            `ARS_OFF_PSEL: rd_next = {par_pend_reg, par_sel_reg};
            `ARS_OFF_QUEUE: rd_next = {27'h0, q_arm_reg, q_full, q_cnt};
            `ARS_OFF_INJ: rd_next = {27'h0, inj_pend_reg, inj_ch_reg};
            `ARS_OFF_LIM: rd_next = lim_reg;
            `ARS_OFF_WFR: rd_next = {24'h0, wfr_reg};
            `ARS_OFF_EMUX: rd_next = {19'h0, emux_sel_o, emux_reg};
            `ARS_OFF_STAT: rd_next = {valid_reg, 5'h0, rptr_reg, 1'b0, wptr_reg,
                                      cv_pd_o, state_reg};
            `ARS_OFF_FIFO: rd_next = {valid_reg[{1'b0, rptr_reg}], 10'h0, res0_mem[rptr_reg]};
            `ARS_OFF_IRQS: rd_next = {28'h0, irq_stat_reg};
            `ARS_OFF_IRQM: rd_next = {28'h0, irq_mask_reg};
            `ARS_OFF_DIGIN: rd_next = {16'h0, ain_s2 & ~dis_reg};
            `ARS_OFF_DIS: rd_next = {16'h0, dis_reg};
            default: begin
                if (is_res && !res_ai[3]) begin
                    rd_next = {valid_reg[res_ai], 10'h0, res0_mem[res_ai[2:0]]};
                end else if (is_res) begin
                    rd_next = {valid_reg[res_ai], 21'h0, res1_mem[res_ai[2:0]]};
                end
            end
        endcase
    end
    always @(posedge clk_i) begin
        if (srst_i) begin
            prdata_o <= 32'h0000_0000;
            err_reg <= 1'b0;
        end else if (ce_i && apb_setup) begin
            prdata_o <= pwrite_i ? 32'h0000_0000 : rd_next;
            err_reg <= ~ars_mapped(paddr_i);
        end
    end
    // converter core controls
    assign cv_sample_o = (state_reg == ST_SAMP);
    assign cv_convert_o = (state_reg == ST_CONV);
    assign cv_res8_o = res8;
    assign cv1_ch_o = {`ARS_SHARED_HI, emux_reg[`ARS_EMUX_SCH]};
    assign cv1_en_o = sync & (state_reg != ST_IDLE);
    assign cv_pd_o = ~en | (ctrl_reg[`ARS_CTRL_APD] & (state_reg == ST_IDLE));
    assign bw_pre_o = (state_reg == ST_PRE);
    assign mux_test_o = ctrl_reg[`ARS_CTRL_MTEST];
    assign dig_dis_o = dis_reg;
endmodule // ars_adc_seq
`default_nettype wire

// ### hdl/ars_consts.vh
// constants for the adc request sequencer: offsets, fields, reset values
// Contract
// - 10-bit results, optional faster 8-bit mode
// - 12 + 4 channels, 4 shared by both
// - programmable sample and conversion durations
// - parallel requests armed together, fixed order
// - queued requests convert in entry order
// - inserted channel leaves running sequence intact
// - highest priority pending source wins arbitration
// - sources started by software or triggers
// - results reduced by limit check or accumulation
// - eight result registers chainable as fifo
// - per-register wait-for-read against overwrite
// - completion request lets transfer unit move results
// - both converters can sample in sync
// - external multiplexer select driven automatically
// - unused analog pins readable as digital inputs
// - per-pin digital input disable
// - auto power-down while no conversion runs
// - broken wire detection and multiplexer test
`ifndef ARS_CONSTS_VH
`define ARS_CONSTS_VH
// register byte offsets
`define ARS_OFF_CTRL 8'h00
`define ARS_OFF_TIM 8'h04
`define ARS_OFF_PSEL 8'h08
`define ARS_OFF_QUEUE 8'h0c
`define ARS_OFF_INJ 8'h10
`define ARS_OFF_CMD 8'h14
`define ARS_OFF_LIM 8'h18
`define ARS_OFF_WFR 8'h1c
`define ARS_OFF_EMUX 8'h20
`define ARS_OFF_STAT 8'h24
`define ARS_OFF_FIFO 8'h28
`define ARS_OFF_IRQS 8'h2c
`define ARS_OFF_IRQM 8'h30
`define ARS_OFF_DIGIN 8'h34
`define ARS_OFF_DIS 8'h38
`define ARS_RES_BASE 2'h1
// control fields
`define ARS_CTRL_EN 0
`define ARS_CTRL_RES8 1
`define ARS_CTRL_APD 2
`define ARS_CTRL_SYNC 3
`define ARS_CTRL_CHAIN 4
`define ARS_CTRL_MTEST 5
`define ARS_CTRL_BWD 6
`define ARS_CTRL_RED 9:8
`define ARS_CTRL_ACCN 11:10
`define ARS_CTRL_PPRIO 13:12
`define ARS_CTRL_QPRIO 15:14
`define ARS_CTRL_PTSEL 17:16
`define ARS_CTRL_PTEN 18
`define ARS_CTRL_QTSEL 20:19
`define ARS_CTRL_QTEN 21
// reduction modes
`define ARS_RED_NONE 2'h0
`define ARS_RED_LIMIT 2'h1
`define ARS_RED_ACC 2'h2
// timing, emux, limit fields
`define ARS_TIM_SAMP 7:0
`define ARS_TIM_CONV 15:8
`define ARS_LIM_LO 9:0
`define ARS_LIM_HI 25:16
`define ARS_EMUX_CH 3:0
`define ARS_EMUX_LAST 6:4
`define ARS_EMUX_SCH 9:8
// command bits
`define ARS_CMD_PSTART 0
`define ARS_CMD_QSTART 1
`define ARS_CMD_QFLUSH 2
// interrupt status bits
`define ARS_IRQ_DONE 0
`define ARS_IRQ_LIMIT 1
`define ARS_IRQ_SEQEND 2
`define ARS_IRQ_BLOCK 3
// reset values
`define ARS_CTRL_RST 32'h0000_0000
`define ARS_TIM_RST 32'h0000_0303
`define ARS_LIM_RST 32'h03ff_0000
// channel map: shared group sits at the top of the channel range
`define ARS_SHARED_HI 2'h3
`endif

// ### sim/ars_adc_seq_props.sv
// assertion checker for the adc request sequencer ports
`timescale 1ns/10ps
`default_nettype none
module ars_adc_seq_props (
    // clock, reset and apb
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // converter side
    input wire logic cv_sample_o,
    input wire logic cv_convert_o,
    input wire logic cv_pd_o,
    input wire logic xfer_req_o,
    input wire logic [15:0] dig_dis_o
);
    logic dis_wr_reg = 0;
    logic rst_reg = 1;
    // pin disable lands one edge after its write; rst_reg masks reset
    always @(posedge clk_i) begin
        dis_wr_reg <= psel_i && penable_i && pwrite_i && paddr_i == 8'h38;
        rst_reg <= srst_i;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    sequence s_access;
        psel_i && penable_i;
    endsequence
    sequence s_conv_start;
        cv_sample_o ##1 cv_convert_o;
    endsequence
    AST_PREADY: assert property (pready_o == (psel_i && penable_i))
        else $error("pready differs from access phase");
    AST_SLVERR: assert property (pslverr_o |-> s_access)
        else $error("error response outside access");
    AST_SAMP_CONV: assert property ($rose(cv_convert_o) |-> $past(cv_sample_o))
        else $error("conversion without sample phase");
    AST_CONV_MIN: assert property (s_conv_start |-> cv_convert_o [*8])
        else $error("conversion shorter than eight cycles");
    AST_XFER_SRC: assert property ($rose(xfer_req_o) |->
        !$past(cv_convert_o) && $past(cv_convert_o, 2)) else $error("request not after store");
    AST_XFER_PULSE: assert property (xfer_req_o |=> !xfer_req_o)
        else $error("transfer request too long");
    AST_PD_IDLE: assert property (cv_pd_o |-> !cv_sample_o && !cv_convert_o)
        else $error("powered down while converting");
    AST_DIS_WRITE: assert property (!rst_reg && $changed(dig_dis_o) |-> dis_wr_reg)
        else $error("pin disable moved without a write");
endmodule // ars_adc_seq_props
bind ars_adc_seq ars_adc_seq_props ars_adc_seq_props_inst (.*);
`default_nettype wire

// ### sim/ars_core_model.sv
// behavioural converter core answering with a channel code
`timescale 1ns/10ps
`default_nettype none
module ars_core_model (
    // clock and converter controls
    input wire logic clk_i,
    input wire logic cv_convert_i,
    input wire logic [3:0] cv0_ch_i,
    input wire logic [3:0] cv1_ch_i,
    // results
    output logic [9:0] res0_o,
    output logic [9:0] res1_o
);
    logic conv_d_reg = 0;
    logic [9:0] res0_reg = 10'h155;
    logic [9:0] res1_reg = 10'h2aa;
    assign res0_o = res0_reg;
    assign res1_o = res1_reg;
    // code holds through store; toggles otherwise to expose late samples
    always @(posedge clk_i) begin
        conv_d_reg <= cv_convert_i;
        if (cv_convert_i || conv_d_reg) begin
            res0_reg <= {cv0_ch_i, 6'h2a};
            res1_reg <= {~cv1_ch_i, 6'h15};
        end else begin
            res0_reg <= ~res0_reg;
            res1_reg <= ~res1_reg;
        end
    end
endmodule // ars_core_model
`default_nettype wire

// ### sim/tb_ars_adc_seq.sv
// self-checking bench for the adc request sequencer
`timescale 1ns/10ps
`default_nettype none
`include "ars_consts.vh"
module tb_ars_adc_seq;
    logic clk_i = 0, srst_i = 1, psel = 0, pen = 0, pwr = 0, samp_d = 0;
    logic [7:0] pa = 0;
    logic [31:0] pwd = 0, d, mm;
    logic [3:0] trig = 0;
    logic [15:0] ain = 0;
    wire [31:0] prd;
    wire rdy, err, samp, conv, pd, xreq, irq, mtest, r8;
    wire [9:0] r0, r1;
    wire [3:0] ch0, ch1;
    wire [2:0] emux;
    wire [15:0] dis;
    int n_errors = 0, n_checks = 0, k, nsamp = 0, n0;
    logic [32:0] rq[$];
    logic [31:0] mq[$];
    logic [3:0] cq[$];
    // free-running clock
    always #50 clk_i = ~clk_i;
    ars_adc_seq ars_adc_seq_inst (.clk_i(clk_i), .srst_i(srst_i), .ce_i(1'b1), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd),
        .pready_o(rdy), .pslverr_o(err), .ext_trig_i(trig), .ain_dig_i(ain), .cv0_res_i(r0),
        .cv1_res_i(r1), .cv_sample_o(samp), .cv_convert_o(conv), .cv0_ch_o(ch0),
        .cv1_ch_o(ch1), .cv1_en_o(), .cv_res8_o(r8), .cv_pd_o(pd), .bw_pre_o(),
        .mux_test_o(mtest), .emux_sel_o(emux), .dig_dis_o(dis), .xfer_req_o(xreq),
        .irq_o(irq));
    ars_core_model ars_core_model_inst (.clk_i(clk_i), .cv_convert_i(conv), .cv0_ch_i(ch0),
        .cv1_ch_i(ch1), .res0_o(r0), .res1_o(r1));
    task chk(input string nm, input logic [32:0] e, input logic [32:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // one apb transfer, held until pready is sampled high
    task bus(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i);
        psel <= 1;
        pwr <= w;
        pa <= a;
        pwd <= v;
        @(posedge clk_i);
        pen <= 1;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (rdy !== 1'b1 && k < 16);
        if (rdy !== 1'b1) begin
            n_errors++;
            results;
        end
        psel <= 0;
        pen <= 0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        bus(1, a, v);
    endtask
    task rd(input logic [7:0] a, input logic [32:0] e, input logic [31:0] m);
        rq.push_back(e);
        mq.push_back(m);
        bus(0, a, 0);
    endtask
    // wait for n transfer requests
    task wx(input int n);
        repeat (n) begin
            k = 0;
            do begin
                @(negedge clk_i);
                k++;
            end while (xreq !== 1'b1 && k < 300);
            if (xreq !== 1'b1) begin
                n_errors++;
                results;
            end
        end
    endtask
    // read data judged at the completing edge
    always @(posedge clk_i) if (psel && pen && rdy && !pwr && rq.size() > 0) begin
        mm = mq.pop_front();
        chk("apb read", rq.pop_front() & {1'b1, mm}, {err, prd & mm});
    end
    // channel of each started conversion
    always @(posedge clk_i) begin
        samp_d <= samp;
        if (samp && !samp_d) begin
            nsamp++;
            chk("channel", cq.size() > 0 ? {29'h0, cq.pop_front()} : 33'h10, {29'h0, ch0});
        end
    end
    initial begin
        k = $urandom(32'ha4f8ec6c);
        repeat (16) @(posedge clk_i);
        srst_i <= 0;
        rd(`ARS_OFF_CTRL, 33'h0, 32'hffffffff);
        rd(`ARS_OFF_TIM, 33'h303, 32'hffffffff);
        rd(`ARS_OFF_LIM, 33'h3ff0000, 32'hffffffff);
        rd(8'h3c, 33'h100000000, 32'hffffffff);
        chk("power down", 1, pd);
        wr(`ARS_OFF_CTRL, 32'h20);
        @(negedge clk_i);
        chk("mux test", 1, mtest);
        d = $urandom;
        wr(`ARS_OFF_DIS, d);
        ain <= d[31:16];
        repeat (4) @(posedge clk_i);
        rd(`ARS_OFF_DIGIN, {17'h0, d[31:16] & ~d[15:0]}, 32'hffff);
        chk("pin disable", d[15:0], dis);
        $display("done reset and pins");
        wr(`ARS_OFF_TIM, 0);
        for (int m = 0; m < 2; m++) begin
            wr(`ARS_OFF_CTRL, 1 | (m << 1));
            cq = {cq, 4'd2, 4'd6, 4'd9};
            wr(`ARS_OFF_PSEL, 32'h244);
            wr(`ARS_OFF_CMD, 1);
            wx(3);
            chk("res8", m, r8);
            rd(8'h48, {1'b0, 32'h80020000 | (m ? 32'h2a : 32'haa)}, 32'h800f3fff);
            rd(8'h48, 33'h0, 32'h80000000);
        end
        wr(`ARS_OFF_CTRL, 1);
        wr(`ARS_OFF_QUEUE, 7);
        wr(`ARS_OFF_QUEUE, 3);
        wr(`ARS_OFF_QUEUE, 11);
        cq = {cq, 4'd4, 4'd7, 4'd3, 4'd11};
        wr(`ARS_OFF_PSEL, 32'h10);
        wr(`ARS_OFF_CMD, 3);
        wx(4);
        cq = {cq, 4'd0, 4'd8, 4'd1, 4'd13};
        wr(`ARS_OFF_PSEL, 32'h2003);
        wr(`ARS_OFF_CMD, 1);
        wr(`ARS_OFF_INJ, 8);
        wx(4);
        $display("done sequences");
        wr(`ARS_OFF_IRQS, 32'hf);
        wr(`ARS_OFF_LIM, 32'h03000100);
        wr(`ARS_OFF_CTRL, 32'h101);
        cq = {cq, 4'd2, 4'd5};
        wr(`ARS_OFF_PSEL, 32'h24);
        wr(`ARS_OFF_CMD, 1);
        wx(1);
        repeat (20) @(posedge clk_i);
        rd(8'h48, 33'h800200aa, 32'h800f3fff);
        chk("irq masked", 0, irq);
        wr(`ARS_OFF_IRQM, 2);
        @(negedge clk_i);
        chk("irq", 1, irq);
        wr(`ARS_OFF_IRQS, 2);
        @(negedge clk_i);
        chk("irq cleared", 0, irq);
        $display("done limit and irq");
        wr(`ARS_OFF_CTRL, 32'h601);
        cq = {cq, 4'd2, 4'd2};
        wr(`ARS_OFF_PSEL, 32'h4);
        wr(`ARS_OFF_CMD, 1);
        wr(`ARS_OFF_CMD, 1);
        wx(1);
        rd(8'h48, 33'h80020154, 32'h800f3fff);
        rd(8'h4c, 33'h0, 32'h0);
        wr(`ARS_OFF_CTRL, 32'h5);
        wr(`ARS_OFF_WFR, 32'h8);
        @(negedge clk_i);
        chk("auto power down", 1, pd);
        cq = {cq, 4'd3, 4'd3};
        wr(`ARS_OFF_PSEL, 32'h8);
        wr(`ARS_OFF_CMD, 1);
        wx(1);
        n0 = nsamp;
        wr(`ARS_OFF_CMD, 1);
        repeat (30) @(negedge clk_i);
        chk("held", n0, nsamp);
        rd(`ARS_OFF_IRQS, 33'h8, 32'h8);
        rd(8'h4c, 33'h80000000, 32'h80000000);
        wx(1);
        $display("done wait for read");
        wr(`ARS_OFF_WFR, 0);
        wr(`ARS_OFF_EMUX, 32'h124);
        wr(`ARS_OFF_CTRL, 32'h60009);
        cq = {cq, 4'd4};
        wr(`ARS_OFF_PSEL, 32'h10);
        trig <= 4'h4;
        repeat (4) @(posedge clk_i);
        trig <= 0;
        wx(1);
        chk("second channel", 4'hd, ch1);
        chk("ext mux", 1, emux);
        rd(8'h70, 33'h80000095, 32'h800003ff);
        wr(`ARS_OFF_CTRL, 32'h11);
        cq = {cq, 4'd10, 4'd12};
        wr(`ARS_OFF_PSEL, 32'h1400);
        wr(`ARS_OFF_CMD, 1);
        wx(2);
        rd(`ARS_OFF_FIFO, 33'h800a0000, 32'h800f0000);
        rd(`ARS_OFF_FIFO, 33'h800c0000, 32'h800f0000);
        repeat (20) @(negedge clk_i);
        chk("left over", 0, cq.size());
        $display("done sync and chain");
        results;
    end
endmodule // tb_ars_adc_seq
`default_nettype wire
